// >>> ccm_pkg.sv
// Purpose: shared constants and types for the capture/compare mode control block
// Assumes: register index = byte address / 4 on a 32-bit AHB-Lite bus
// Notes: one table entry per channel, up to six channels
package ccm_pkg;

  localparam int CH_MAX = 6;
  localparam int WDOG_CH = 5;

  typedef logic [7:0] ccm_idx_t;

  // ***************************************************
  // register indexes
  // ***************************************************
  localparam ccm_idx_t IDX_STAT = 8'hD8;
  localparam ccm_idx_t IDX_CTRL = 8'hD9;
  localparam ccm_idx_t IDX_CYCLE = 8'hDF;
  localparam ccm_idx_t IDX_MASK = 8'hE6;
  localparam ccm_idx_t IDX_MODE [CH_MAX] = '{8'hDA, 8'hDB, 8'hDC, 8'hE3, 8'hE4, 8'hE5};
  localparam ccm_idx_t IDX_CPL [CH_MAX] = '{8'hFB, 8'hE9, 8'hEB, 8'hF0, 8'hF2, 8'hF4};
  localparam ccm_idx_t IDX_CPH [CH_MAX] = '{8'hFC, 8'hEA, 8'hEC, 8'hF1, 8'hF3, 8'hF5};

  // ***************************************************
  // fields and reset values
  // ***************************************************
  localparam int WATCHDOG_ENABLE_BIT = 6;
  localparam int CYCLE_LENGTH_SELECT_LSB = 0;
  localparam logic [15:0] PWM_BASE = 16'h0100;
  localparam logic [15:0] FULL_MSK = 16'hFFFF;
  localparam logic [1:0] CYCLE_LENGTH_SELECT_RST = 2'h0;

  typedef struct packed {
    logic wide_pwm_select;
    logic comparator_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_flag_enable;
    logic toggle_on_match_enable;
    logic pulse_width_enable;
    logic channel_flag_irq_enable;
  } ccm_mode_s;

  localparam ccm_mode_s MODE_RST = '0;

  typedef struct packed {
    logic sel;
    logic write;
    ccm_idx_t idx;
  } ccm_ap_s;

endpackage

// >>> ccm_top.sv
// Purpose: capture/compare mode control for the counter array channels
// Assumes: main counter value arrives on ref_clk; channel pins are asynchronous
// Notes: reads take one wait state, writes none
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps

// Function
// [RULE1] wide select picks 16-bit or shared-length PWM
// [RULE2] comparator enable gates all compare matches
// [RULE3] rising pin edge captures counter when enabled
// [RULE4] falling edge captures too; both means either
// [RULE5] match with match enable sets channel flag
// [RULE6] toggle enable inverts pin on each match
// [RULE7] toggle plus PWM gives frequency output
// [RULE8] PWM enable drives pulse waveform on pin
// [RULE9] PWM width follows wide select bit
// [RULE10] flag irq enable masks channel interrupt
// [RULE11] watchdog enable locks module five mode; low/high compare byte writes still clear/set its comparator enable
// [RULE12] cycle length field selects 8..11 bits
// [RULE13] low byte write clears comparator enable
// [RULE14] high byte write sets comparator enable
// [RULE15] mode registers read/write, reset to zero
module ccm_top #(
  parameter int NUM_CH = 6
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [15:0] cnt_value,
  input wire logic [NUM_CH-1:0] channel_io_pin_in,
  output logic [NUM_CH-1:0] channel_io_pin_out,
  output logic [NUM_CH-1:0] channel_io_pin_oe,
  output logic watchdog_active,
  output logic ccm_irq
);

  if (NUM_CH < 1 || NUM_CH > ccm_pkg::CH_MAX) begin : g_bad_ch
    $error("NUM_CH out of range");
  end

  // ***************************************************
  // bus slave
  // ***************************************************
  ccm_pkg::ccm_ap_s ap_q;
  logic rd_done_q;
  logic rd_wait;
  logic we;
  logic [31:0] rd_val;
  logic [31:0] hrdata_q;

  assign rd_wait = ap_q.sel && !ap_q.write && !rd_done_q;
  assign we = ap_q.sel && ap_q.write;
  assign hreadyout = !rd_wait;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ap_q <= '0;
    end else if (hready) begin
      // hsize is ignored: any transfer with htrans[1] set is served as a whole word
      ap_q.sel <= hsel && htrans[1];
      ap_q.write <= hwrite;
      ap_q.idx <= haddr[9:2];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= rd_wait;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_wait) begin
      hrdata_q <= rd_val;
    end
  end

  // ***************************************************
  // configuration registers
  // ***************************************************
  ccm_pkg::ccm_mode_s mode_q [NUM_CH];
  logic [15:0] cp_q [NUM_CH];
  logic watchdog_enable_q;
  logic [1:0] cycle_length_select_q;
  logic [NUM_CH-1:0] mask_q;
  logic [NUM_CH-1:0] flag_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_enable_q <= 1'b0;
      cycle_length_select_q <= ccm_pkg::CYCLE_LENGTH_SELECT_RST;
      mask_q <= '0;
    end else if (we) begin
      if (ap_q.idx == ccm_pkg::IDX_CTRL) begin
        watchdog_enable_q <= hwdata[ccm_pkg::WATCHDOG_ENABLE_BIT];
      end
      if (ap_q.idx == ccm_pkg::IDX_CYCLE) begin
        cycle_length_select_q <= hwdata[ccm_pkg::CYCLE_LENGTH_SELECT_LSB +: 2]; // RULE12
      end
      if (ap_q.idx == ccm_pkg::IDX_MASK) begin
        mask_q <= hwdata[NUM_CH-1:0];
      end
    end
  end

  assign watchdog_active = watchdog_enable_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        mode_q[i] <= ccm_pkg::MODE_RST; // RULE15
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (we && ap_q.idx == ccm_pkg::IDX_MODE[i]) begin
          // module five serves as watchdog while enabled
          if (!(i == ccm_pkg::WDOG_CH && watchdog_enable_q)) begin // RULE11
            mode_q[i] <= ccm_pkg::ccm_mode_s'(hwdata[7:0]); // RULE15
          end
        end else if (we && ap_q.idx == ccm_pkg::IDX_CPL[i]) begin
          mode_q[i].comparator_enable <= 1'b0; // RULE13
        end else if (we && ap_q.idx == ccm_pkg::IDX_CPH[i]) begin
          mode_q[i].comparator_enable <= 1'b1; // RULE14
        end
      end
    end
  end

  // ***************************************************
  // pin sampling and compare
  // ***************************************************
  logic [NUM_CH-1:0] pin_s1_q;
  logic [NUM_CH-1:0] pin_s2_q;
  logic [NUM_CH-1:0] pin_s3_q;
  logic [NUM_CH-1:0] rise;
  logic [NUM_CH-1:0] fall;
  logic [NUM_CH-1:0] cap_ev;
  logic [NUM_CH-1:0] match;
  logic [NUM_CH-1:0] wrap;
  logic [NUM_CH-1:0] match_q;
  logic [NUM_CH-1:0] wrap_q;
  logic [NUM_CH-1:0] match_ev;
  logic [NUM_CH-1:0] wrap_ev;
  logic [NUM_CH-1:0] capp_v;
  logic [NUM_CH-1:0] capn_v;
  logic [NUM_CH-1:0] mat_v;
  logic [NUM_CH-1:0] eccf_v;
  logic [15:0] msk [NUM_CH];
  logic [15:0] pwm_msk;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= channel_io_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign rise = pin_s2_q & ~pin_s3_q;
  assign fall = ~pin_s2_q & pin_s3_q;
  assign pwm_msk = (ccm_pkg::PWM_BASE << cycle_length_select_q) - 16'h0001; // RULE12

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      capp_v[i] = mode_q[i].rising_capture_enable;
      capn_v[i] = mode_q[i].falling_capture_enable;
      mat_v[i] = mode_q[i].match_flag_enable;
      eccf_v[i] = mode_q[i].channel_flag_irq_enable;
      if (mode_q[i].pulse_width_enable && !mode_q[i].wide_pwm_select) begin
        msk[i] = pwm_msk; // RULE1 RULE9
      end else begin
        msk[i] = ccm_pkg::FULL_MSK; // RULE1 RULE9
      end
      match[i] = mode_q[i].comparator_enable && (((cnt_value ^ cp_q[i]) & msk[i]) == 16'h0000); // RULE2
      wrap[i] = (cnt_value & msk[i]) == 16'h0000;
    end
  end

  assign cap_ev = (rise & capp_v) | (fall & capn_v); // RULE3 RULE4

  // a held counter value must not fire the same match twice
  assign match_ev = match & ~match_q;
  assign wrap_ev = wrap & ~wrap_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      match_q <= '0;
      wrap_q <= '0;
    end else begin
      match_q <= match;
      wrap_q <= wrap;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cp_q[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (we && ap_q.idx == ccm_pkg::IDX_CPL[i]) begin
          cp_q[i][7:0] <= hwdata[7:0];
        end else if (we && ap_q.idx == ccm_pkg::IDX_CPH[i]) begin
          cp_q[i][15:8] <= hwdata[7:0];
        end else if (cap_ev[i]) begin
          cp_q[i] <= cnt_value; // RULE3 RULE4
        end else if (match_ev[i] && mode_q[i].toggle_on_match_enable && mode_q[i].pulse_width_enable) begin
          cp_q[i][7:0] <= 8'(cp_q[i][7:0] + cp_q[i][15:8]); // RULE7
        end
      end
    end
  end

  // ***************************************************
  // pin drive
  // ***************************************************
  logic [NUM_CH-1:0] out_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (mode_q[i].pulse_width_enable && mode_q[i].toggle_on_match_enable) begin
          if (match_ev[i]) begin
            out_q[i] <= !out_q[i]; // RULE7
          end
        end else if (mode_q[i].pulse_width_enable) begin
          // match wins over wrap so a zero compare value gives zero duty
          if (match_ev[i]) begin
            out_q[i] <= 1'b0; // RULE8
          end else if (wrap_ev[i]) begin
            out_q[i] <= 1'b1; // RULE8
          end
        end else if (mode_q[i].toggle_on_match_enable && match_ev[i]) begin
          out_q[i] <= !out_q[i]; // RULE6
        end
      end
    end
  end

  assign channel_io_pin_out = out_q;

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      channel_io_pin_oe[i] = mode_q[i].pulse_width_enable || mode_q[i].toggle_on_match_enable;
    end
  end

  // ***************************************************
  // flags and interrupt
  // ***************************************************
  logic stat_rd;
  logic [NUM_CH-1:0] flag_set;

  assign stat_rd = rd_wait && ap_q.idx == ccm_pkg::IDX_STAT;
  assign flag_set = cap_ev | (match_ev & mat_v); // RULE5

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= '0;
    end else begin
      // a new event in the clearing read's cycle survives
      flag_q <= (stat_rd ? '0 : flag_q) | flag_set; // RULE5
    end
  end

  assign ccm_irq = |(flag_q & mask_q & eccf_v); // RULE10

  always_comb begin
    rd_val = 32'h00000000;
    if (ap_q.idx == ccm_pkg::IDX_STAT) begin
      rd_val[NUM_CH-1:0] = flag_q;
    end
    if (ap_q.idx == ccm_pkg::IDX_MASK) begin
      rd_val[NUM_CH-1:0] = mask_q;
    end
    if (ap_q.idx == ccm_pkg::IDX_CTRL) begin
      rd_val[ccm_pkg::WATCHDOG_ENABLE_BIT] = watchdog_enable_q;
    end
    if (ap_q.idx == ccm_pkg::IDX_CYCLE) begin
      rd_val[ccm_pkg::CYCLE_LENGTH_SELECT_LSB +: 2] = cycle_length_select_q;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (ap_q.idx == ccm_pkg::IDX_MODE[i]) begin
        rd_val[7:0] = mode_q[i];
      end
      if (ap_q.idx == ccm_pkg::IDX_CPL[i]) begin
        rd_val[7:0] = cp_q[i][7:0];
      end
      if (ap_q.idx == ccm_pkg::IDX_CPH[i]) begin
        rd_val[7:0] = cp_q[i][15:8];
      end
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_wide;
    mode_q[0].pulse_width_enable && mode_q[0].wide_pwm_select |-> msk[0] == 16'hFFFF;
  endproperty
  a_wide: assert property (p_wide) else $error("wide pwm not full width"); // RULE1

  property p_narrow;
    mode_q[0].pulse_width_enable && !mode_q[0].wide_pwm_select && cycle_length_select_q == 2'h0 |-> msk[0] == 16'h00FF;
  endproperty
  a_narrow: assert property (p_narrow) else $error("8-bit pwm mask wrong"); // RULE9

  property p_cyc11;
    mode_q[0].pulse_width_enable && !mode_q[0].wide_pwm_select && cycle_length_select_q == 2'h3 |-> msk[0] == 16'h07FF;
  endproperty
  a_cyc11: assert property (p_cyc11) else $error("11-bit pwm mask wrong"); // RULE12

  property p_ecom;
    !mode_q[0].comparator_enable |-> !match[0];
  endproperty
  a_ecom: assert property (p_ecom) else $error("match while comparator off"); // RULE2

  property p_rcap;
    !we && $rose(pin_s2_q[0]) && mode_q[0].rising_capture_enable |=> cp_q[0] == $past(cnt_value);
  endproperty
  a_rcap: assert property (p_rcap) else $error("rising capture missed"); // RULE3

  property p_fcap;
    !we && $fell(pin_s2_q[0]) && mode_q[0].falling_capture_enable |=> cp_q[0] == $past(cnt_value);
  endproperty
  a_fcap: assert property (p_fcap) else $error("falling capture missed"); // RULE4

  property p_flag;
    match_ev[0] && mode_q[0].match_flag_enable |=> flag_q[0];
  endproperty
  a_flag: assert property (p_flag) else $error("match flag not set"); // RULE5

  property p_tog;
    match_ev[0] && mode_q[0].toggle_on_match_enable && !mode_q[0].pulse_width_enable
      |=> out_q[0] != $past(out_q[0]);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle missed"); // RULE6

  property p_freq;
    !we && match_ev[0] && mode_q[0].toggle_on_match_enable && mode_q[0].pulse_width_enable && !cap_ev[0]
      |=> out_q[0] != $past(out_q[0]) && cp_q[0][7:0] == 8'($past(cp_q[0][7:0]) + $past(cp_q[0][15:8]));
  endproperty
  a_freq: assert property (p_freq) else $error("frequency output step wrong"); // RULE7

  property p_pwm;
    wrap_ev[0] && !match_ev[0] && mode_q[0].pulse_width_enable && !mode_q[0].toggle_on_match_enable
      |=> out_q[0] ##1 channel_io_pin_oe[0];
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm cycle start missed"); // RULE8

  property p_irq;
    flag_q[0] && mask_q[0] && eccf_v[0] |-> ccm_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled flag gave no interrupt"); // RULE10

  property p_irq_off;
    (flag_q & eccf_v) == '0 |-> !ccm_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt from masked flag"); // RULE10

  property p_lock;
    watchdog_enable_q && we && ap_q.idx == ccm_pkg::IDX_MODE[NUM_CH-1] && NUM_CH - 1 == ccm_pkg::WDOG_CH
      |=> $stable(mode_q[NUM_CH-1]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked mode register changed"); // RULE11

  property p_cpl;
    we && ap_q.idx == ccm_pkg::IDX_CPL[0] |=> !mode_q[0].comparator_enable;
  endproperty
  a_cpl: assert property (p_cpl) else $error("low byte write kept comparator"); // RULE13

  property p_cph;
    we && ap_q.idx == ccm_pkg::IDX_CPH[0] |=> mode_q[0].comparator_enable;
  endproperty
  a_cph: assert property (p_cph) else $error("high byte write left comparator off"); // RULE14

  property p_mode;
    we && ap_q.idx == ccm_pkg::IDX_MODE[0] |=> mode_q[0] == $past(hwdata[7:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode write lost"); // RULE15

  c_cap: cover property (cap_ev[0] ##1 flag_q[0]);
  c_freq: cover property (match_ev[0] && mode_q[0].toggle_on_match_enable && mode_q[0].pulse_width_enable);
  c_irq: cover property (ccm_irq ##[1:20] stat_rd);
  c_lock: cover property (watchdog_enable_q && we && ap_q.idx == ccm_pkg::IDX_MODE[NUM_CH-1]);

endmodule

// >>> tb.sv
// Purpose: self-checking bench for the capture/compare mode control block
// Assumes: reads take one wait state, writes none; counter value and pins come from the bench
// Notes: hsize is tied to word size, hready is looped back from hreadyout
`timescale 1ns/1ps
module tb;
  logic ref_clk, rstn, hsel, hwrite, hreadyout, hresp, wd, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [15:0] cnt;
  logic [5:0] pin_in, pin_out, pin_oe;
  int err_count, total_checks, cyc;

  ccm_top uut (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .cnt_value(cnt), .channel_io_pin_in(pin_in),
    .channel_io_pin_out(pin_out), .channel_io_pin_oe(pin_oe), .watchdog_active(wd), .ccm_irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ***************************************************
  // checks and bus cycles
  // ***************************************************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // limit is several times the expected run, so only a hang reaches it
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      end_sim;
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    chk_reg({31'h0, got}, {31'h0, exp}, m);
  endtask

  // hready and read data are taken at the rising edge that ends the phase
  task automatic wait_rdy;
    forever begin
      @(posedge ref_clk);
      if (hreadyout === 1'b1) break;
    end
    rd = hrdata;
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    // outputs launched by the closing edge are settled by the falling edge
    @(negedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, {24'h0, d});
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e, input string m);
    xfer(1'b0, idx, 32'h0);
    chk_reg(rd, {24'h0, e}, m);
  endtask

  task automatic setcnt(input logic [15:0] v);
    @(posedge ref_clk);
    cnt <= v;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // pin edge needs three edges to be seen; five leaves margin
  task automatic pin_edge(input logic [15:0] v, input logic lvl);
    @(posedge ref_clk);
    cnt <= v;
    pin_in[0] <= lvl;
    repeat (5) @(posedge ref_clk);
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_reset;
    for (int i = 0; i < 6; i++) rdc(ccm_pkg::IDX_MODE[i], 8'h00, "mode reset");
    chk_bit(irq, 1'b0, "irq reset");
    chk_reg({26'h0, pin_oe}, 32'h0, "oe reset");
  endtask

  task automatic t_toggle;
    wr(ccm_pkg::IDX_CPL[0], 8'h10);
    wr(ccm_pkg::IDX_CPH[0], 8'h00);
    wr(ccm_pkg::IDX_MODE[0], 8'h44);
    setcnt(16'h0010);
    chk_bit(pin_out[0], 1'b1, "toggle 1");
    setcnt(16'h0000);
    chk_bit(pin_out[0], 1'b1, "no match hold");
    setcnt(16'h0010);
    chk_bit(pin_out[0], 1'b0, "toggle 2");
    chk_bit(pin_oe[0], 1'b1, "toggle oe");
  endtask

  task automatic t_side;
    wr(ccm_pkg::IDX_MODE[1], 8'h40);
    wr(ccm_pkg::IDX_CPL[1], 8'h12);
    rdc(ccm_pkg::IDX_MODE[1], 8'h00, "low clears");
    wr(ccm_pkg::IDX_CPH[1], 8'h34);
    rdc(ccm_pkg::IDX_MODE[1], 8'h40, "high sets");
  endtask

  task automatic t_match;
    wr(ccm_pkg::IDX_MODE[0], 8'h09);
    xfer(1'b0, ccm_pkg::IDX_STAT, 32'h0);
    wr(ccm_pkg::IDX_MASK, 8'h01);
    setcnt(16'h0000);
    setcnt(16'h0010);
    rdc(ccm_pkg::IDX_STAT, 8'h00, "comparator off");
    wr(ccm_pkg::IDX_MODE[0], 8'h49);
    setcnt(16'h0000);
    setcnt(16'h0010);
    chk_bit(irq, 1'b1, "irq on");
    rdc(ccm_pkg::IDX_STAT, 8'h01, "match flag");
    chk_bit(irq, 1'b0, "irq cleared");
    wr(ccm_pkg::IDX_MODE[0], 8'h48);
    setcnt(16'h0000);
    setcnt(16'h0010);
    chk_bit(irq, 1'b0, "irq masked");
    rdc(ccm_pkg::IDX_STAT, 8'h01, "masked flag");
    wr(ccm_pkg::IDX_MODE[0], 8'h00);
  endtask

  task automatic pwmc(input logic [15:0] v, input logic e);
    setcnt(v);
    chk_bit(pin_out[0], e, "pwm level");
  endtask

  task automatic t_pwm;
    for (int v = 0; v < 4; v++) begin
      wr(ccm_pkg::IDX_CYCLE, 8'(v));
      rdc(ccm_pkg::IDX_CYCLE, 8'(v), "cycle length");
    end
    wr(ccm_pkg::IDX_CYCLE, 8'h00);
    wr(ccm_pkg::IDX_CPL[0], 8'h80);
    wr(ccm_pkg::IDX_CPH[0], 8'h01);
    wr(ccm_pkg::IDX_MODE[0], 8'h42);
    pwmc(16'h0000, 1'b1);
    chk_bit(pin_oe[0], 1'b1, "pwm oe");
    pwmc(16'h0080, 1'b0);
    pwmc(16'h0100, 1'b1);
    wr(ccm_pkg::IDX_CYCLE, 8'h01);
    pwmc(16'h0080, 1'b1);
    pwmc(16'h0180, 1'b0);
    pwmc(16'h0100, 1'b0);
    pwmc(16'h0200, 1'b1);
    wr(ccm_pkg::IDX_CYCLE, 8'h03);
    pwmc(16'h0180, 1'b0);
    pwmc(16'h0400, 1'b0);
    pwmc(16'h0800, 1'b1);
    wr(ccm_pkg::IDX_MODE[0], 8'hC2);
    pwmc(16'h0180, 1'b0);
    pwmc(16'h0200, 1'b0);
    pwmc(16'h0000, 1'b1);
    wr(ccm_pkg::IDX_MODE[0], 8'h00);
    wr(ccm_pkg::IDX_CYCLE, 8'h00);
  endtask

  task automatic t_freq;
    // channel 0 leaves the pwm scenario driving high, so the first toggle goes low
    wr(ccm_pkg::IDX_CPL[0], 8'h05);
    wr(ccm_pkg::IDX_CPH[0], 8'h10);
    wr(ccm_pkg::IDX_MODE[0], 8'h46);
    setcnt(16'h1005);
    chk_bit(pin_out[0], 1'b0, "freq 1");
    rdc(ccm_pkg::IDX_CPL[0], 8'h15, "freq step");
    setcnt(16'h1015);
    chk_bit(pin_out[0], 1'b1, "freq 2");
    wr(ccm_pkg::IDX_MODE[0], 8'h00);
  endtask

  task automatic t_capture;
    wr(ccm_pkg::IDX_MODE[0], 8'h20);
    xfer(1'b0, ccm_pkg::IDX_STAT, 32'h0);
    pin_edge(16'h1234, 1'b1);
    rdc(ccm_pkg::IDX_CPL[0], 8'h34, "rise low");
    rdc(ccm_pkg::IDX_CPH[0], 8'h12, "rise high");
    rdc(ccm_pkg::IDX_STAT, 8'h01, "capture flag");
    pin_edge(16'h5678, 1'b0);
    rdc(ccm_pkg::IDX_CPL[0], 8'h34, "fall ignored");
    wr(ccm_pkg::IDX_MODE[0], 8'h10);
    pin_edge(16'h2222, 1'b1);
    rdc(ccm_pkg::IDX_CPL[0], 8'h34, "rise ignored");
    pin_edge(16'h3333, 1'b0);
    rdc(ccm_pkg::IDX_CPL[0], 8'h33, "fall capture");
    wr(ccm_pkg::IDX_MODE[0], 8'h30);
    pin_edge(16'h4444, 1'b1);
    rdc(ccm_pkg::IDX_CPL[0], 8'h44, "both rise");
    pin_edge(16'h5555, 1'b0);
    rdc(ccm_pkg::IDX_CPL[0], 8'h55, "both fall");
    wr(ccm_pkg::IDX_MODE[0], 8'h00);
  endtask

  task automatic t_wdog;
    wr(ccm_pkg::IDX_MODE[5], 8'h01);
    wr(ccm_pkg::IDX_CTRL, 8'h40);
    chk_bit(wd, 1'b1, "watchdog on");
    wr(ccm_pkg::IDX_MODE[5], 8'hFF);
    rdc(ccm_pkg::IDX_MODE[5], 8'h01, "locked mode");
    wr(ccm_pkg::IDX_CTRL, 8'h00);
    chk_bit(wd, 1'b0, "watchdog off");
    wr(ccm_pkg::IDX_MODE[5], 8'hFF);
    rdc(ccm_pkg::IDX_MODE[5], 8'hFF, "unlocked mode");
    wr(ccm_pkg::IDX_MODE[5], 8'h00);
  endtask

  task automatic t_rw;
    for (int i = 0; i < 6; i++) begin
      wr(ccm_pkg::IDX_MODE[i], 8'hA5);
      rdc(ccm_pkg::IDX_MODE[i], 8'hA5, "mode a5");
      wr(ccm_pkg::IDX_MODE[i], 8'h5A);
      rdc(ccm_pkg::IDX_MODE[i], 8'h5A, "mode 5a");
      wr(ccm_pkg::IDX_MODE[i], 8'h00);
    end
    wr(8'h10, 8'hFF);
    rdc(8'h10, 8'h00, "unmapped");
    chk_bit(hresp, 1'b0, "okay response");
  endtask

  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    cnt = 16'h0;
    pin_in = 6'h00;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset;
    t_toggle;
    t_side;
    t_match;
    t_pwm;
    t_freq;
    t_capture;
    t_wdog;
    t_rw;
    end_sim;
  end
endmodule
